// file: src/emi_regs.svh
// Constant values of the external memory interface: fields, reset values and cycle counts.
`ifndef EMI_REGS_SVH
`define EMI_REGS_SVH

// -----------------------------------------------------------------------------
// Memory-mode field encodings (ext_mem_config[3:2]).
// -----------------------------------------------------------------------------
`define EMI_MODE_INTERNAL   2'b00
`define EMI_MODE_SPLIT_NB   2'b01
`define EMI_MODE_SPLIT_BS   2'b10
`define EMI_MODE_EXTERNAL   2'b11

// -----------------------------------------------------------------------------
// Configuration field positions and reset value.
// -----------------------------------------------------------------------------
`define EMI_CFG_NONMUX_BIT  4
`define EMI_CFG_MODE_HI     3
`define EMI_CFG_MODE_LO     2
`define EMI_CFG_ALE_HI      1
`define EMI_CFG_ALE_LO      0
`define EMI_CFG_RESET       5'h03

// -----------------------------------------------------------------------------
// Timing control field positions; reset puts setup and hold at their maximum.
// -----------------------------------------------------------------------------
`define EMI_TC_SETUP_HI     7
`define EMI_TC_SETUP_LO     6
`define EMI_TC_STROBE_HI    5
`define EMI_TC_STROBE_LO    2
`define EMI_TC_HOLD_HI      1
`define EMI_TC_HOLD_LO      0
`define EMI_TC_RESET        8'hff

// -----------------------------------------------------------------------------
// On-chip data RAM size and fixed cycle counts of an off-chip access.
// -----------------------------------------------------------------------------
`define EMI_RAM_BYTES       17'h02000
`define EMI_RAM_AW          13
`define EMI_ADR_CYCLES      4'h2
`define EMI_FIN_CYCLES      4'h2
`define EMI_ALE_MIN_CYCLES  4'h2

`endif

// file: src/emi_pkg.sv
// Types shared by the external memory interface design files.
`default_nettype none
package emi_pkg;
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_RAM,
    ST_ADR,
    ST_ALE,
    ST_SET,
    ST_STB,
    ST_HLD,
    ST_FIN
  } emi_phase_t;
endpackage : emi_pkg
`default_nettype wire

// file: src/emi_xdata_ram.sv
// On-chip data RAM with registered read data.
`default_nettype none
module emi_data_ram #(
  parameter int AW = 13
) (
  input  wire logic          ref_clk,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [7:0]    wdata,
  output logic      [7:0]    rdata
);
  logic [7:0] mem [0:(1<<AW)-1];

  // Write-first is not needed: the controller never reads and writes in one cycle.
  always_ff @(posedge ref_clk) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule : emi_data_ram
`default_nettype wire

// file: src/emi_top.sv
// External memory interface: on-chip/off-chip steering and off-chip bus timing.
`default_nettype none
`include "emi_regs.svh"
module emi_top (
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  input  wire logic        cfg_wr,
  input  wire logic [4:0]  cfg_wdata,
  input  wire logic        tc_wr,
  input  wire logic [7:0]  tc_wdata,
  input  wire logic [7:0]  ext_mem_page_high_byte,
  input  wire logic        req,
  input  wire logic        req_write,
  input  wire logic        req_word,
  input  wire logic [7:0]  index_reg,
  input  wire logic [15:0] data_pointer,
  input  wire logic [7:0]  req_wdata,
  input  wire logic [7:0]  data_in,
  output logic             busy,
  output logic             done,
  output logic [7:0]       rdata,
  output logic [4:0]       ext_mem_config,
  output logic [7:0]       ext_mem_timing_ctrl,
  output logic [15:0]      addr_out,
  output logic             addr_hi_oe_n,
  output logic             addr_lo_oe_n,
  output logic [7:0]       data_out,
  output logic             data_oe_n,
  output logic             rd_n,
  output logic             wr_n,
  output logic             ale
);
  // ---------------------------------------------------------------------------
  // State record.
  // ---------------------------------------------------------------------------
  typedef struct packed {
    emi_pkg::emi_phase_t phase;
    logic [3:0]          cnt;
    logic [4:0]          cfg;
    logic [7:0]          tc;
    logic                is_wr;
    logic                busy;
    logic                done;
    logic [7:0]          rdata;
    logic [15:0]         addr;
    logic                hi_oe_n;
    logic                lo_oe_n;
    logic [7:0]          dout;
    logic                d_oe_n;
    logic                rd_n;
    logic                wr_n;
    logic                ale;
    logic [7:0]          din_s1;
    logic [7:0]          din_s2;
    logic [1:0]          cap;
  } emi_regs_t;

  emi_regs_t r;
  emi_regs_t next_r;

  // ---------------------------------------------------------------------------
  // Address formation and steering.
  // ---------------------------------------------------------------------------
  logic [1:0]  mode;
  logic [15:0] eff_addr;
  logic        on_chip;
  logic        drive_hi;
  logic [1:0]  t_setup;
  logic [3:0]  t_strobe;
  logic [1:0]  t_hold;
  logic [1:0]  t_ale;
  logic        ram_we;
  logic [7:0]  ram_q;

  assign mode     = r.cfg[`EMI_CFG_MODE_HI:`EMI_CFG_MODE_LO];
  assign t_setup  = r.tc[`EMI_TC_SETUP_HI:`EMI_TC_SETUP_LO];
  assign t_strobe = r.tc[`EMI_TC_STROBE_HI:`EMI_TC_STROBE_LO];
  assign t_hold   = r.tc[`EMI_TC_HOLD_HI:`EMI_TC_HOLD_LO];
  assign t_ale    = r.cfg[`EMI_CFG_ALE_HI:`EMI_CFG_ALE_LO];

  // Byte moves join page and index; word moves use the data pointer whole.
  assign eff_addr = req_word ? data_pointer
                             : {ext_mem_page_high_byte, index_reg};

  // Internal-only and external-only modes bypass the size compare, so external-only never reaches RAM.
  assign on_chip = (mode == `EMI_MODE_INTERNAL) ||
                   ((mode != `EMI_MODE_EXTERNAL) &&
                    ({1'b0, eff_addr} < `EMI_RAM_BYTES));

  // Upper lines are left to the port latches for byte moves except in bank select.
  assign drive_hi = req_word || (mode == `EMI_MODE_SPLIT_BS);
  // On-chip writes land at the taking edge, so the RAM phase only reports completion.
  assign ram_we = req && !r.busy && on_chip && req_write;

  emi_data_ram #(
    .AW (`EMI_RAM_AW)
  ) u_data_ram (
    .ref_clk (ref_clk),
    .we      (ram_we),
    .addr    (eff_addr[`EMI_RAM_AW-1:0]),
    .wdata   (req_wdata),
    .rdata   (ram_q)
  );

  // ---------------------------------------------------------------------------
  // Next-state logic.
  // ---------------------------------------------------------------------------
  always_comb begin
    next_r        = r;
    next_r.done   = 1'b0;
    next_r.din_s1 = data_in;
    next_r.din_s2 = r.din_s1;
    next_r.cap    = {r.cap[0], 1'b0}; // Tracks strobe-time data through the synchroniser.
    next_r.rdata  = (r.cap[1] && !r.is_wr) ? r.din_s2 : r.rdata;
    if (cfg_wr) begin
      next_r.cfg = cfg_wdata;
    end
    if (tc_wr) begin
      next_r.tc = tc_wdata;
    end
    case (r.phase)
      emi_pkg::ST_IDLE: begin
        if (req) begin
          next_r.busy  = 1'b1;
          next_r.is_wr = req_write;
          if (on_chip) begin
            next_r.phase = emi_pkg::ST_RAM;
          end else begin
            next_r.phase   = emi_pkg::ST_ADR;
            next_r.cnt     = `EMI_ADR_CYCLES - 4'h1;
            next_r.addr    = drive_hi ? eff_addr : {8'h00, eff_addr[7:0]};
            next_r.hi_oe_n = !drive_hi;
            next_r.lo_oe_n = 1'b0;
            next_r.dout    = req_wdata;
            next_r.d_oe_n  = !req_write;
          end
        end
      end
      emi_pkg::ST_RAM: begin
        next_r.rdata = r.is_wr ? r.rdata : ram_q;
        next_r.done  = 1'b1;
        next_r.busy  = 1'b0;
        next_r.phase = emi_pkg::ST_IDLE;
      end
      emi_pkg::ST_ADR, emi_pkg::ST_ALE, emi_pkg::ST_SET: begin
        if (r.cnt != 4'h0) begin
          next_r.cnt = r.cnt - 4'h1;
        end else if (r.phase == emi_pkg::ST_ADR && !r.cfg[`EMI_CFG_NONMUX_BIT]) begin
          // Latch pulse lasts the field plus two cycles.
          next_r.phase = emi_pkg::ST_ALE;
          next_r.cnt   = {2'b00, t_ale} + `EMI_ALE_MIN_CYCLES - 4'h1;
          next_r.ale   = 1'b1;
        end else if (r.phase != emi_pkg::ST_SET && t_setup != 2'b00) begin
          next_r.phase = emi_pkg::ST_SET;
          next_r.cnt   = {2'b00, t_setup} - 4'h1;
          next_r.ale   = 1'b0;
        end else begin
          next_r.phase = emi_pkg::ST_STB;
          next_r.cnt   = t_strobe;
          next_r.ale   = 1'b0;
          next_r.rd_n  = r.is_wr;
          next_r.wr_n  = !r.is_wr;
        end
      end
      emi_pkg::ST_STB: begin
        if (r.cnt != 4'h0) begin
          next_r.cnt = r.cnt - 4'h1;
        end else begin
          // Data seen in the last strobe cycle reaches rdata two edges later, so a
          // part that drives the bus only under the strobe is still read correctly.
          next_r.cap   = 2'b01;
          next_r.rd_n  = 1'b1;
          next_r.wr_n  = 1'b1;
          if (t_hold != 2'b00) begin
            next_r.phase = emi_pkg::ST_HLD;
            next_r.cnt   = {2'b00, t_hold} - 4'h1;
          end else begin
            next_r.phase = emi_pkg::ST_FIN;
            next_r.cnt   = `EMI_FIN_CYCLES - 4'h1;
          end
        end
      end
      emi_pkg::ST_HLD: begin
        if (r.cnt != 4'h0) begin
          next_r.cnt = r.cnt - 4'h1;
        end else begin
          next_r.phase = emi_pkg::ST_FIN;
          next_r.cnt   = `EMI_FIN_CYCLES - 4'h1;
        end
      end
      default: begin
        if (r.cnt != 4'h0) begin
          next_r.cnt = r.cnt - 4'h1;
        end else begin
          next_r.phase   = emi_pkg::ST_IDLE;
          next_r.done    = 1'b1;
          next_r.busy    = 1'b0;
          next_r.hi_oe_n = 1'b1;
          next_r.lo_oe_n = 1'b1;
          next_r.d_oe_n  = 1'b1;
        end
      end
    endcase
  end

  // ---------------------------------------------------------------------------
  // State register.
  // ---------------------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      r         <= '0;
      r.phase   <= emi_pkg::ST_IDLE;
      r.cfg     <= `EMI_CFG_RESET;
      r.tc      <= `EMI_TC_RESET;
      r.hi_oe_n <= 1'b1;
      r.lo_oe_n <= 1'b1;
      r.d_oe_n  <= 1'b1;
      r.rd_n    <= 1'b1;
      r.wr_n    <= 1'b1;
    end else begin
      r <= next_r;
    end
  end
  // Every output is a register field, so nothing combinational reaches a pin.
  assign busy                = r.busy;
  assign done                = r.done;
  assign rdata               = r.rdata;
  assign ext_mem_config      = r.cfg;
  assign ext_mem_timing_ctrl = r.tc;
  assign addr_out            = r.addr;
  assign addr_hi_oe_n        = r.hi_oe_n;
  assign addr_lo_oe_n        = r.lo_oe_n;
  assign data_out            = r.dout;
  assign data_oe_n           = r.d_oe_n;
  assign rd_n                = r.rd_n;
  assign wr_n                = r.wr_n;
  assign ale                 = r.ale;

  // ---------------------------------------------------------------------------
  // Checks.
  // ---------------------------------------------------------------------------
  // Busy cycles are counted so the shortest-access check needs no long repetition.
  int unsigned busy_len;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      busy_len <= 0;
    end else begin
      busy_len <= r.busy ? busy_len + 1 : 0;
    end
  end
  ext_only_offchip_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (req && !busy && mode == `EMI_MODE_EXTERNAL) |=> (r.phase == emi_pkg::ST_ADR))
    else $error("external-only move went on chip");
  internal_only_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (req && !busy && mode == `EMI_MODE_INTERNAL) |=> (r.phase == emi_pkg::ST_RAM))
    else $error("internal-only move left the chip");
  split_low_onchip_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (req && !busy && mode == `EMI_MODE_SPLIT_NB && eff_addr < 16'h2000)
      |=> (r.phase == emi_pkg::ST_RAM))
    else $error("split mode low address went off chip");
  upper_float_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (req && !busy && !req_word && mode == `EMI_MODE_EXTERNAL) |=> addr_hi_oe_n)
    else $error("byte move drove upper address lines");
  word_addr_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (req && !busy && req_word && mode == `EMI_MODE_EXTERNAL)
      |=> (!addr_hi_oe_n && addr_out == $past(data_pointer)))
    else $error("word move address not driven from data pointer");
  bank_select_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    (req && !busy && !req_word && mode == `EMI_MODE_SPLIT_BS && !on_chip)
      |=> (addr_out == {$past(ext_mem_page_high_byte), $past(index_reg)}))
    else $error("bank select address wrong");
  min_nonmux_len_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    ($fell(busy) && r.cfg[`EMI_CFG_NONMUX_BIT] && $past(r.phase) == emi_pkg::ST_FIN)
      |-> ($past(busy_len) >= 4))
    else $error("off-chip access shorter than five cycles");
  ale_width_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    $rose(ale) |-> ale [*2])
    else $error("latch pulse shorter than two cycles");
  strobe_exclusive_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    !(ale && (!rd_n || !wr_n)))
    else $error("latch and strobe overlap");
endmodule : emi_top
`default_nettype wire

// file: verif/emi_ext_mem.sv
// Behavioural off-chip memory that answers the external bus of the interface.
`default_nettype none
module emi_ext_mem (
  input  wire logic        ref_clk,
  input  wire logic        slow,
  input  wire logic [15:0] addr_out,
  input  wire logic        addr_hi_oe_n,
  input  wire logic        addr_lo_oe_n,
  input  wire logic [7:0]  data_out,
  input  wire logic        data_oe_n,
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  output logic      [7:0]  data_in,
  output int               strobes,
  output logic      [15:0] last_ea,
  output logic             last_hi
);
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------------------
  // Storage and bus decode
  // ---------------------------------------------------------------------------
  logic [7:0]  mem [0:65535];
  logic [15:0] ea;
  logic        drv;
  logic        prev_n = 1'b1;
  logic [7:0]  din_q  = 8'h00;
  int          n_stb  = 0;
  // Undriven upper lines read as zero, as if the port latches were cleared.
  assign ea = {addr_hi_oe_n ? 8'h00 : addr_out[15:8], addr_out[7:0]};
  // The address is trusted only while the low lines are driven; a slow part waits for the strobe.
  assign drv = !addr_lo_oe_n && data_oe_n && (!slow || !rd_n);
  // A released bus shows the inverse of its last value, so stale data never passes as a read.
  always @(drv, ea) din_q = drv ? mem[ea] : ~din_q;
  assign data_in = din_q;
  // Each first low cycle of a strobe counts one transfer; writes are stored while the strobe is low.
  assign strobes = n_stb;
  always @(posedge ref_clk) begin
    prev_n <= rd_n && wr_n;
    if (!wr_n && !data_oe_n) mem[ea] <= data_out;
    if (prev_n && !(rd_n && wr_n)) begin
      n_stb <= n_stb + 1;
      last_ea <= ea;
      last_hi <= !addr_hi_oe_n;
    end
  end
endmodule : emi_ext_mem
`default_nettype wire

// file: verif/tb_top.sv
// Self-checking testbench of the external memory interface.
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  // ---------------------------------------------------------------------------
  // Signals, design and partner
  // ---------------------------------------------------------------------------
  logic        ref_clk = 1'b0, rst_n = 1'b0, cfg_wr = 1'b0, tc_wr = 1'b0, req = 1'b0;
  logic        req_write = 1'b0, req_word = 1'b0, slow = 1'b0;
  logic [4:0]  cfg_wdata = 5'h00, cfgr;
  logic [7:0]  tc_wdata = 8'h00, page = 8'h00, index_reg = 8'h00, req_wdata = 8'h00;
  logic [7:0]  data_in, rdata, tcr, data_out, rd;
  logic [15:0] data_pointer = 16'h0000, addr_out, last_ea;
  logic        busy, done, hi_oe_n, lo_oe_n, data_oe_n, rd_n, wr_n, ale, last_hi;
  int          err_total = 0, n_checks = 0, strobes, n, ale_hi = 0;
  always #12.5 ref_clk = ~ref_clk;
  // Latch-pulse cycles are tallied here so a scenario can judge the pulse width.
  always @(posedge ref_clk) begin
    if (ale === 1'b1) ale_hi <= ale_hi + 1;
  end
  emi_top uut (
    .ref_clk(ref_clk), .rst_n(rst_n), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata),
    .tc_wr(tc_wr), .tc_wdata(tc_wdata), .ext_mem_page_high_byte(page),
    .req(req), .req_write(req_write), .req_word(req_word), .index_reg(index_reg),
    .data_pointer(data_pointer), .req_wdata(req_wdata), .data_in(data_in),
    .busy(busy), .done(done), .rdata(rdata), .ext_mem_config(cfgr),
    .ext_mem_timing_ctrl(tcr), .addr_out(addr_out), .addr_hi_oe_n(hi_oe_n),
    .addr_lo_oe_n(lo_oe_n), .data_out(data_out), .data_oe_n(data_oe_n),
    .rd_n(rd_n), .wr_n(wr_n), .ale(ale)
  );
  emi_ext_mem mem_model (
    .ref_clk(ref_clk), .slow(slow), .addr_out(addr_out), .addr_hi_oe_n(hi_oe_n),
    .addr_lo_oe_n(lo_oe_n), .data_out(data_out), .data_oe_n(data_oe_n), .rd_n(rd_n),
    .wr_n(wr_n), .data_in(data_in), .strobes(strobes), .last_ea(last_ea), .last_hi(last_hi)
  );
  // ---------------------------------------------------------------------------
  // Shared tasks
  // ---------------------------------------------------------------------------
  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : finish_test
  // Both strobes fire together; an extra edge lets the readback settle before it is judged.
  task automatic set_cfg(input logic [4:0] c, input logic [7:0] t);
    cfg_wdata = c;
    tc_wdata = t;
    cfg_wr = 1'b1;
    tc_wr = 1'b1;
    @(posedge ref_clk);
    #1;
    cfg_wr = 1'b0;
    tc_wr = 1'b0;
    @(posedge ref_clk);
    #1;
    chk("config readback", 16'(cfgr), 16'(c));
    chk("timing readback", 16'(tcr), 16'(t));
  endtask : set_cfg
  // One request; req may be held for hold extra cycles while busy, which must be ignored.
  // Returns in the done cycle, so the next call issues its request back to back.
  task automatic xfer(input logic w, input logic wd, input logic [15:0] a, input logic [7:0] d,
                      input int hold, input int en, input int es);
    int s0;
    s0 = strobes;
    req_write = w;
    req_word = wd;
    page = a[15:8];
    index_reg = a[7:0];
    data_pointer = a;
    req_wdata = d;
    req = 1'b1;
    @(posedge ref_clk);
    #1;
    n = 1; // The taking edge already opens the first busy cycle.
    repeat (hold) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    req = 1'b0;
    repeat (100) begin
      @(posedge ref_clk);
      #1;
      if (done === 1'b1) break;
      n++;
    end
    rd = rdata;
    chk("access done", {15'h0000, done}, 16'h0001);
    chk("busy cycles", 16'(n), 16'(en));
    chk("off-chip strobes", 16'(strobes - s0), 16'(es));
  endtask : xfer
  // ---------------------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------------------
  task automatic t_reset();
    chk("config reset", 16'(cfgr), 16'h0003);
    chk("timing reset", 16'(tcr), 16'h00ff);
    chk("bus idle", {12'h000, rd_n, wr_n, hi_oe_n, lo_oe_n}, 16'h000f);
  endtask : t_reset
  // Reset leaves mode 00; aliases above 8 kB must land on the same on-chip byte.
  task automatic t_internal();
    xfer(1'b1, 1'b1, 16'h0123, 8'ha5, 0, 1, 0);
    xfer(1'b0, 1'b0, 16'h2123, 8'h00, 0, 1, 0);
    chk("wrapped byte read", 16'(rd), 16'h00a5);
    xfer(1'b0, 1'b1, 16'he123, 8'h00, 0, 1, 0);
    chk("wrapped word read", 16'(rd), 16'h00a5);
  endtask : t_internal
  // Reads go to a part that drives data only under the strobe, even a one-cycle strobe.
  task automatic t_timing();
    logic [4:0] cf [6] = '{5'h1c, 5'h1c, 5'h0c, 5'h0f, 5'h1c, 5'h0f};
    logic [7:0] tc [6] = '{8'h00, 8'hff, 8'h00, 8'h44, 8'h81, 8'hff};
    int         ex [6] = '{5, 26, 7, 12, 8, 31};
    int         a0;
    slow = 1'b1;
    for (int i = 0; i < 6; i++) begin
      set_cfg(cf[i], tc[i]);
      a0 = ale_hi;
      xfer(1'b1, 1'b1, 16'h1000 + 16'(i), 8'h30 + 8'(i), 0, ex[i], 1);
      xfer(1'b0, 1'b1, 16'h1000 + 16'(i), 8'h00, 0, ex[i], 1);
      chk("off-chip read back", 16'(rd), 16'h0030 + 16'(i));
      chk("latch cycles", 16'(ale_hi - a0), 16'(cf[i][4] ? 0 : 2 * (cf[i][1:0] + 2)));
    end
    slow = 1'b0;
  endtask : t_timing
  // Both split modes; word moves probe the last on-chip and first off-chip address, byte moves 1f40 and 2041.
  task automatic t_split();
    for (int m = 1; m < 3; m++) begin
      set_cfg({1'b1, 2'(m), 2'b00}, 8'h00);
      xfer(1'b1, 1'b0, 16'h1f40, 8'h11, 0, 1, 0);
      xfer(1'b1, 1'b0, 16'h2041, 8'h3c, 0, 5, 1);
      chk("byte upper lines", 16'(last_hi), 16'(m == 2));
      chk("byte bus address", last_ea, (m == 2) ? 16'h2041 : 16'h0041);
      xfer(1'b1, 1'b1, 16'h1fff, 8'h22, 0, 1, 0);
      xfer(1'b1, 1'b1, 16'h2000, 8'h44, 0, 5, 1);
      chk("word upper lines", 16'(last_hi), 16'h0001);
      chk("word bus address", last_ea, 16'h2000);
    end
  endtask : t_split
  task automatic t_external();
    set_cfg(5'h1c, 8'h00);
    xfer(1'b1, 1'b1, 16'h0123, 8'h5b, 0, 5, 1);
    chk("word bus address", last_ea, 16'h0123);
    chk("word upper lines", 16'(last_hi), 16'h0001);
    xfer(1'b1, 1'b0, 16'h4410, 8'h66, 0, 5, 1);
    chk("byte upper lines", 16'(last_hi), 16'h0000);
    chk("byte bus address", last_ea, 16'h0010);
    xfer(1'b0, 1'b1, 16'h0010, 8'h00, 0, 5, 1);
    chk("byte write lands low", 16'(rd), 16'h0066);
    set_cfg(5'h10, 8'h00);
    xfer(1'b0, 1'b1, 16'h0123, 8'h00, 0, 1, 0);
    chk("on-chip untouched", 16'(rd), 16'h00a5);
  endtask : t_external
  // A slow part answers only under the strobe; requests held during busy are dropped.
  task automatic t_slow();
    set_cfg(5'h1c, 8'h0c);
    slow = 1'b1;
    xfer(1'b0, 1'b1, 16'h0123, 8'h00, 2, 8, 1);
    chk("slow read data", 16'(rd), 16'h005b);
    @(posedge ref_clk);
    #1;
    chk("refused request", {15'h0000, busy}, 16'h0000);
    slow = 1'b0;
  endtask : t_slow
  // ---------------------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------------------
  initial begin
    repeat (2) @(posedge ref_clk);
    #1;
    rst_n = 1'b1;
    t_reset();
    t_internal();
    t_timing();
    t_split();
    t_external();
    t_slow();
    finish_test();
  end
  // The tests need well under 1500 cycles; 4000 leaves margin without hiding a hang.
  initial begin
    #(4000 * 25);
    err_total++;
    finish_test();
  end
endmodule : tb_top
`default_nettype wire
